/* File: verilog/pnp_map.vh */
// Constants for the resource data reader: card states, store layout and reset values.
// Assumes inclusion by bare name from the design file only.
`ifndef PNP_MAP_VH
`define PNP_MAP_VH

// ----------------------------------------
// Card states
// ----------------------------------------
`define ST_WAIT_KEY   2'h0
`define ST_SLEEP      2'h1
`define ST_ISOLATION  2'h2
`define ST_CONFIG     2'h3

// ----------------------------------------
// Serial store layout
// ----------------------------------------
`define STORE_DEPTH   64
`define STORE_AW      6
`define LEN_ADDR      6'h00
`define ID_START      6'h01
`define RES_START     6'h0a
`define BITS_PER_BYTE 3'h7

// ----------------------------------------
// Reset values and preload FIFO size
// ----------------------------------------
`define CSN_RESET     8'h00
`define LEN_RESET     6'h3f
`define FIFO_WIDTH    8
`define FIFO_DEPTH    8

`endif

/* File: verilog/pnp_resource_data_reader.v */
// Resource data reader of a plug and play card, with the preload FIFO it uses.
// Assumes host strobes are decoded on clk_sys by the bus front end; only the
// bus reset drive pin comes from outside the clock domain.
//
// Operation
// R1: Resource data served only in Configuration
// R2: Enter Configuration on isolation win or wake
// R3: Identifier and resource data share one store
// R4: Any wake resets the shared pointer
// R5: Host reads identifier first after direct wake
// R6: Identifier bytes valid after wake
// R7: Checksum after wake invalid, host ignores it
// R8: After isolation, first read gives resource data
// R9: Ready bit only with a full byte
// R10: Host polls ready before each read
// R11: Hardware shifts eight bits per byte
// R12: Data read clears, refills, sets ready
// R13: Status reads leave ready and pointer alone
// R14: Each read advances pointer, wraps at length
// R15: Store preloaded: length, identifier, resource data
// R16: Bus reset drive: Wait for Key, number zero
// R17: Wake zero in Sleep isolates unnumbered cards
`timescale 1ns/1ps
`include "pnp_map.vh"

// ----------------------------------------
// Preload FIFO
// ----------------------------------------
module pnp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys,
    input  wire             rst_n,
    input  wire             inValid,
    input  wire [WIDTH-1:0] inData,
    output wire             inReady,
    output wire             outValid,
    output wire [WIDTH-1:0] outData,
    input  wire             outReady
);
    reg [WIDTH-1:0] memFf [0:DEPTH-1];   // Storage words
    reg [AW-1:0]    wrPtrFf;             // Write index
    reg [AW-1:0]    rdPtrFf;             // Read index
    reg [AW:0]      countFf;             // Words held
    wire            doPush;
    wire            doPop;

    assign inReady  = (countFf != DEPTH);
    assign outValid = (countFf != 0);
    assign outData  = memFf[rdPtrFf];
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;

    // Storage write, no reset needed for data words
    always @(posedge clk_sys) begin
        if (doPush) begin
            memFf[wrPtrFf] <= inData;
        end
    end

    // Pointers and fill level
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPtrFf <= {AW{1'b0}};
            rdPtrFf <= {AW{1'b0}};
            countFf <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                wrPtrFf <= (wrPtrFf == DEPTH - 1) ? {AW{1'b0}} : wrPtrFf + 1'b1;
            end
            if (doPop) begin
                rdPtrFf <= (rdPtrFf == DEPTH - 1) ? {AW{1'b0}} : rdPtrFf + 1'b1;
            end
            // Push and pop together leave the level unchanged
            if (doPush && !doPop) begin
                countFf <= countFf + 1'b1;
            end else if (doPop && !doPush) begin
                countFf <= countFf - 1'b1;
            end
        end
    end
endmodule // pnp_fifo

// ----------------------------------------
// Resource data reader
// ----------------------------------------
module pnp_resource_data_reader (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       busResetDrive,      // Pin, active high
    input  wire       keyDetected,        // Initiation key seen
    input  wire       waitForKeyCmd,      // Return to Wait for Key
    input  wire       resetCsnCmd,        // Clear card number
    input  wire       wakeCmd,            // Wake command strobe
    input  wire [7:0] wakeOperand,        // Wake command data
    input  wire       isolationWin,       // Card number assigned after isolation
    input  wire [7:0] assignedCsn,        // Number written on win
    input  wire       isolationLose,      // Card lost isolation
    input  wire       dataRead,           // Resource data register read
    input  wire       loadRestart,        // Restart preload at address zero
    input  wire       loadValid,
    input  wire [7:0] loadData,
    output wire       loadReady,
    output wire       readyBit,           // Status bit zero
    output wire [7:0] resourceData,       // Resource data register
    output wire [1:0] cardState,
    output wire [7:0] cardSelectNumber
);
    localparam FILL_IDLE  = 1'b0;
    localparam FILL_SHIFT = 1'b1;

    reg [7:0]             storeFf [0:`STORE_DEPTH-1]; // Serial store
    reg                   rstSync1Ff;      // Pin synchroniser, first stage
    reg                   rstSync2Ff;      // Pin synchroniser, second stage
    reg [1:0]             stateFf;         // Card state
    reg [7:0]             csnFf;           // Card select number
    reg [`STORE_AW-1:0]   ptrFf;           // Shared read pointer
    reg [`STORE_AW-1:0]   lenFf;           // Stored frame length
    reg [`STORE_AW-1:0]   wrAddrFf;        // Preload address
    reg                   fillFf;          // Refill machine state
    reg [2:0]             bitCntFf;        // Bits shifted so far
    reg [7:0]             srcFf;           // Byte being serialised
    reg [7:0]             dataFf;          // Assembled byte
    reg                   readyFf;         // Byte complete
    wire                  fifoValid;
    wire [7:0]            fifoData;
    wire                  storeWrite;
    wire                  inConfig;
    wire                  takeRead;
    reg [1:0]             nxt_state;
    reg [7:0]             nxt_csn;
    reg                   reload;          // Start a refill this cycle
    reg [`STORE_AW-1:0]   nxt_ptr;

    // Wrap past the stored length back to the resource block
    function [`STORE_AW-1:0] advance;
        input [`STORE_AW-1:0] p;
        input [`STORE_AW-1:0] len;
        begin
            advance = (p == len) ? `RES_START : p + 1'b1;
        end
    endfunction

    // ----------------------------------------
    // Preload path
    // ----------------------------------------
    // Store writes wait while a refill shifts its byte (FILL_SHIFT), so the FIFO backs up
    assign storeWrite = fifoValid & (fillFf == FILL_IDLE);

    pnp_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (3)
    ) preloadFifo (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inValid  (loadValid),
        .inData   (loadData),
        .inReady  (loadReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (storeWrite)
    );

    // R15: length then identifier then resource data
    always @(posedge clk_sys) begin
        if (storeWrite) begin
            storeFf[wrAddrFf] <= fifoData;
        end
    end

    // Preload address and frame length capture
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrAddrFf <= `LEN_ADDR;
            lenFf    <= `LEN_RESET;
        end else if (loadRestart) begin
            wrAddrFf <= `LEN_ADDR;
        end else if (storeWrite) begin
            wrAddrFf <= wrAddrFf + 1'b1;
            if (wrAddrFf == `LEN_ADDR) begin
                lenFf <= fifoData[`STORE_AW-1:0];
            end
        end
    end

    // ----------------------------------------
    // Bus reset drive synchroniser
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1Ff <= 1'b0;
            rstSync2Ff <= 1'b0;
        end else begin
            rstSync1Ff <= busResetDrive;
            rstSync2Ff <= rstSync1Ff;
        end
    end

    // ----------------------------------------
    // Card state and pointer decisions
    // ----------------------------------------
    assign inConfig = (stateFf == `ST_CONFIG);
    // R1: reads outside Configuration or before ready are ignored
    assign takeRead = dataRead & inConfig & readyFf;

    always @* begin
        nxt_state = stateFf;
        nxt_csn   = csnFf;
        reload    = 1'b0;
        nxt_ptr   = ptrFf;
        if (rstSync2Ff) begin
            // R16: reset drive, any state to Wait for Key
            nxt_state = `ST_WAIT_KEY;
            nxt_csn   = `CSN_RESET;
        end else if (waitForKeyCmd) begin
            nxt_state = `ST_WAIT_KEY;
        end else begin
            if (resetCsnCmd) begin
                nxt_csn = `CSN_RESET;
            end
            case (stateFf)
                `ST_WAIT_KEY: begin
                    if (keyDetected) begin
                        nxt_state = `ST_SLEEP;
                    end
                end
                `ST_SLEEP: begin
                    if (wakeCmd && wakeOperand == 8'h00 && csnFf == 8'h00) begin
                        // R17: unnumbered cards go to Isolation
                        nxt_state = `ST_ISOLATION;
                    end else if (wakeCmd && wakeOperand == csnFf) begin
                        // R2: matching wake enters Configuration
                        nxt_state = `ST_CONFIG;
                    end
                end
                `ST_ISOLATION: begin
                    if (isolationWin) begin
                        // R2: winner takes its number, enters Configuration
                        nxt_state = `ST_CONFIG;
                        nxt_csn   = assignedCsn;
                    end else if (isolationLose || wakeCmd) begin
                        nxt_state = `ST_SLEEP;
                    end
                end
                default: begin
                    if (wakeCmd && wakeOperand != csnFf) begin
                        nxt_state = `ST_SLEEP;
                    end
                end
            endcase
            if (wakeCmd) begin
                // R4: any wake rewinds to the identifier
                // R6: identifier bytes replayed as stored
                // R7: checksum byte replayed unchecked, may be stale
                reload  = 1'b1;
                nxt_ptr = `ID_START;
            end else if (stateFf == `ST_ISOLATION && isolationWin) begin
                // R8: skip identifier after isolation win
                reload  = 1'b1;
                nxt_ptr = `RES_START;
            end else if (takeRead) begin
                // R14: advance by one, wrap at length
                reload  = 1'b1;
                nxt_ptr = advance(ptrFf, lenFf);
            end
        end
    end

    // State, number and pointer registers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stateFf <= `ST_WAIT_KEY;
            csnFf   <= `CSN_RESET;
            ptrFf   <= `ID_START;
        end else begin
            stateFf <= nxt_state;
            csnFf   <= nxt_csn;
            // R3: one pointer for identifier and resource data
            ptrFf   <= nxt_ptr;
        end
    end

    // ----------------------------------------
    // Byte assembly and ready bit
    // ----------------------------------------
    // Serialising the stored byte costs eight cycles per byte, kept because
    // the card is specified to assemble bytes from a serial source.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fillFf   <= FILL_IDLE;
            bitCntFf <= 3'h0;
            srcFf    <= 8'h00;
            dataFf   <= 8'h00;
            readyFf  <= 1'b0;
        end else if (reload) begin
            // R12: read clears ready, refill starts
            fillFf   <= FILL_SHIFT;
            bitCntFf <= 3'h0;
            srcFf    <= storeFf[nxt_ptr];
            readyFf  <= 1'b0;
        end else begin
            case (fillFf)
                FILL_SHIFT: begin
                    // R11: shift eight bits MSB first
                    dataFf   <= {dataFf[6:0], srcFf[7]};
                    srcFf    <= {srcFf[6:0], 1'b0};
                    bitCntFf <= bitCntFf + 1'b1;
                    if (bitCntFf == `BITS_PER_BYTE) begin
                        // R9: ready only with the full byte
                        fillFf  <= FILL_IDLE;
                        readyFf <= 1'b1;
                    end
                end
                default: begin
                    // R13: hold ready until a data read, wake or isolation win
                    fillFf <= FILL_IDLE;
                end
            endcase
        end
    end

    // R1: status shows ready only in Configuration
    assign readyBit         = readyFf & inConfig;
    assign resourceData     = dataFf;
    assign cardState        = stateFf;
    assign cardSelectNumber = csnFf;
endmodule // pnp_resource_data_reader

/* File: testbench/pnp_reader_chk.sv */
// Checker for the resource data reader, watching only its top ports.
// Assumes one clock domain and the refill timing of nine cycles.
`timescale 1ns/1ps
module pnp_reader_chk (
    input wire       clk_sys,
    input wire       rst_n,
    input wire       busResetDrive,
    input wire       waitForKeyCmd,
    input wire       wakeCmd,
    input wire [7:0] wakeOperand,
    input wire       isolationWin,
    input wire [7:0] assignedCsn,
    input wire       dataRead,
    input wire       readyBit,
    input wire [7:0] resourceData,
    input wire [1:0] cardState,
    input wire [7:0] cardSelectNumber
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // --------------------
    // Sequences
    // --------------------
    // No wake, win, reset drive or Wait for Key strobe, with the card in Configuration
    sequence sQuiet;
        !wakeCmd && !isolationWin && !busResetDrive && !waitForKeyCmd && cardState == 2'h3;
    endsequence
    // A read that the card accepts
    sequence sTakenRead;
        dataRead && readyBit;
    endsequence
    sequence sNoReset;
        !waitForKeyCmd && !busResetDrive;
    endsequence
    // --------------------
    // Assertions
    // --------------------
    a_ready_only_config: assert property (readyBit |-> cardState == 2'h3)
        else $error("ready shown outside configuration");
    a_read_clears_ready: assert property (sTakenRead |=> !readyBit [*8])
        else $error("ready back before eight bits shifted");
    a_refill_sets_ready: assert property (sTakenRead ##1 sQuiet [*8] |=> readyBit)
        else $error("ready not set nine cycles after read");
    a_status_holds: assert property ((readyBit && !dataRead) ##0 sQuiet |=> readyBit && $stable(resourceData))
        else $error("ready or data changed without a read");
    a_win_enters: assert property ((isolationWin && cardState == 2'h2) ##0 sNoReset
        |=> cardState == 2'h3 && cardSelectNumber == $past(assignedCsn))
        else $error("isolation win did not enter configuration");
    a_wake_match: assert property ((wakeCmd && cardState == 2'h1 && wakeOperand != 8'h00
        && wakeOperand == cardSelectNumber) ##0 sNoReset |=> cardState == 2'h3)
        else $error("matching wake did not enter configuration");
    a_wake_zero: assert property ((wakeCmd && wakeOperand == 8'h00 && cardState == 2'h1
        && cardSelectNumber == 8'h00) ##0 sNoReset |=> cardState == 2'h2)
        else $error("wake zero did not isolate");
    a_wake_restart: assert property ((wakeCmd && !busResetDrive) |=> !readyBit)
        else $error("wake did not restart the byte");
    a_bus_reset: assert property (busResetDrive [*4] |=> cardState == 2'h0 && cardSelectNumber == 8'h00)
        else $error("bus reset drive not obeyed");
endmodule // pnp_reader_chk

bind pnp_resource_data_reader pnp_reader_chk chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .busResetDrive(busResetDrive), .waitForKeyCmd(waitForKeyCmd), .wakeCmd(wakeCmd),
    .wakeOperand(wakeOperand), .isolationWin(isolationWin), .assignedCsn(assignedCsn),
    .dataRead(dataRead), .readyBit(readyBit), .resourceData(resourceData),
    .cardState(cardState), .cardSelectNumber(cardSelectNumber));

/* File: testbench/pnp_host_model.sv */
// Host side model: polls the ready bit, then reads the data register.
// Assumes the bench calls its tasks; drives only at falling edges.
`timescale 1ns/1ps
module pnp_host_model (
    input  wire       clk_sys,
    input  wire       readyBit,
    input  wire [7:0] resourceData,
    output reg        dataRead
);
    initial dataRead = 1'b0;
    task automatic readByte(output logic [7:0] b, output logic ok);
        int n;
        ok = 1'b0;
        b = 8'h00;
        // Random pause so the host answers promptly and slowly
        repeat ($urandom_range(0, 3)) @(negedge clk_sys);
        for (n = 0; n < 40 && !ok; n++) begin
            @(negedge clk_sys);
            ok = (readyBit === 1'b1);
        end
        if (ok) begin
            b = resourceData;
            dataRead = 1'b1;
            @(negedge clk_sys);
            dataRead = 1'b0;
        end
    endtask
    // Read while the byte is still shifting; the card must ignore it
    task automatic strayRead();
        @(negedge clk_sys);
        dataRead = 1'b1;
        @(negedge clk_sys);
        dataRead = 1'b0;
    endtask
endmodule // pnp_host_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the resource data reader.
// Assumes the design header layout: length at 0, identifier 1..9, resource from 10.
`timescale 1ns/1ps
`define CHECK_EQ(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_top;
    localparam logic [7:0] LEN = 8'd14; // Last stored address
    logic       clk_sys = 1'b0, rst_n = 1'b0, busResetDrive = 1'b0, loadRestart = 1'b0;
    logic       keyDetected = 1'b0, waitForKeyCmd = 1'b0, resetCsnCmd = 1'b0, wakeCmd = 1'b0;
    logic       isolationWin = 1'b0, isolationLose = 1'b0, loadValid = 1'b0, sawFull = 1'b0;
    logic [7:0] wakeOperand = 8'h00, assignedCsn = 8'h00, loadData = 8'h00, resourceData;
    logic [7:0] cardSelectNumber, store [0:14];
    logic [1:0] cardState;
    wire        dataRead, readyBit, loadReady;
    int         fails = 0, samples_checked = 0, cycles = 0, i;
    initial forever #50 clk_sys = ~clk_sys;
    pnp_resource_data_reader dut (.clk_sys(clk_sys), .rst_n(rst_n), .busResetDrive(busResetDrive),
        .keyDetected(keyDetected), .waitForKeyCmd(waitForKeyCmd), .resetCsnCmd(resetCsnCmd),
        .wakeCmd(wakeCmd), .wakeOperand(wakeOperand), .isolationWin(isolationWin),
        .assignedCsn(assignedCsn), .isolationLose(isolationLose), .dataRead(dataRead),
        .loadRestart(loadRestart), .loadValid(loadValid), .loadData(loadData), .loadReady(loadReady),
        .readyBit(readyBit), .resourceData(resourceData), .cardState(cardState),
        .cardSelectNumber(cardSelectNumber));
    pnp_host_model host (.clk_sys(clk_sys), .readyBit(readyBit), .resourceData(resourceData),
        .dataRead(dataRead));
    // Next store address; wraps to the resource block after the length
    function automatic logic [7:0] nextIdx(input logic [7:0] p);
        return (p == LEN) ? 8'd10 : p + 8'd1;
    endfunction
    // One-cycle command strobe: 0 key, 1 wait, 2 clear number, 3 wake, 4 win, 5 lose
    task automatic cmd(input int k, input logic [7:0] op);
        @(negedge clk_sys);
        {keyDetected, waitForKeyCmd, resetCsnCmd, wakeCmd, isolationWin, isolationLose} = 6'(6'h20 >> k);
        wakeOperand = op;
        assignedCsn = op;
        @(negedge clk_sys);
        {keyDetected, waitForKeyCmd, resetCsnCmd, wakeCmd, isolationWin, isolationLose} = 6'h00;
    endtask
    // Preload under repeated wakes, so the drain stalls and the FIFO fills up
    task automatic preload();
        @(negedge clk_sys);
        loadRestart = 1'b1;
        @(negedge clk_sys);
        loadRestart = 1'b0;
        wakeCmd = 1'b1;
        for (i = 0; i <= LEN; i++) begin
            loadValid = 1'b1;
            loadData = store[i];
            while (loadReady !== 1'b1) begin
                sawFull = 1'b1;
                wakeCmd = 1'b0;
                @(negedge clk_sys);
            end
            @(negedge clk_sys);
        end
        loadValid = 1'b0;
        wakeCmd = 1'b0;
        repeat (30) @(negedge clk_sys);
    endtask
    // Read n bytes from store index p on, with a stray read after each one
    task automatic readRun(input logic [7:0] p, input int n);
        logic [7:0] b;
        logic       ok;
        repeat (n) begin
            host.readByte(b, ok);
            `CHECK_EQ(ok, 1'b1)
            if (p != 8'd9) `CHECK_EQ(b, store[p])
            host.strayRead();
            p = nextIdx(p);
        end
    endtask
    task automatic results();
        $display("checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            results();
        end
    end
    initial begin
        void'($urandom(32'h06410361));
        store[0] = LEN;
        for (i = 1; i <= LEN; i++) store[i] = 8'($urandom);
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        preload();
        `CHECK_EQ(sawFull, 1'b1)
        $display("test preload done");
        cmd(0, 8'h00);
        `CHECK_EQ(cardState, 2'h1)
        cmd(3, 8'h00);
        `CHECK_EQ(cardState, 2'h2)
        cmd(5, 8'h00);
        `CHECK_EQ(cardState, 2'h1)
        cmd(3, 8'h00);
        cmd(4, 8'h05);
        `CHECK_EQ(cardSelectNumber, 8'h05)
        readRun(8'd10, 7);
        $display("test isolation path done");
        cmd(3, 8'h03);
        `CHECK_EQ(cardState, 2'h1)
        cmd(3, 8'h05);
        `CHECK_EQ(cardState, 2'h3)
        readRun(8'd1, 11);
        repeat (20) @(negedge clk_sys);
        `CHECK_EQ(readyBit, 1'b1)
        $display("test wake path done");
        busResetDrive = 1'b1;
        repeat (6) @(negedge clk_sys);
        busResetDrive = 1'b0;
        repeat (4) @(negedge clk_sys);
        `CHECK_EQ({cardState, cardSelectNumber, readyBit}, 11'h000)
        cmd(0, 8'h00);
        cmd(3, 8'h00);
        cmd(4, 8'h07);
        cmd(2, 8'h00);
        `CHECK_EQ(cardSelectNumber, 8'h00)
        cmd(1, 8'h00);
        `CHECK_EQ(cardState, 2'h0)
        $display("test reset paths done");
        results();
    end
endmodule // tb_top
